// ==== dv/draw_flag_asserts.sv ====
`timescale 1ns/1ps
module draw_flag_asserts (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic cmdValid,
	input wire logic cmdReady,
	input wire logic [7:0] cmdOpcode,
	input wire logic [7:0] cmdFlags,
	input wire logic busy,
	input wire logic done
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////////////////////////////////////////////
	a_accept_starts: assert property (cmdValid && cmdReady |=> busy && !cmdValid)
		else $error("accepted command did not start");
	a_pending_held: assert property (cmdValid && !cmdReady |=> cmdValid && $stable(cmdFlags)
		&& $stable(cmdOpcode))
		else $error("waiting command changed");
	a_busy_cause: assert property ($rose(busy) |-> $past(cmdValid) && $past(cmdReady))
		else $error("busy without acceptance");
	a_busy_blocks: assert property (busy |-> !cmdReady)
		else $error("ready while busy");
	a_idle_ready: assert property (!busy |-> cmdReady)
		else $error("not ready while idle");
	a_done_ends: assert property (done |-> busy ##1 (!busy && !done && cmdReady))
		else $error("done not a single closing pulse");
	a_busy_stays: assert property (busy && !done |=> busy)
		else $error("busy dropped without done");
	a_fell_done: assert property ($fell(busy) |-> $past(done))
		else $error("busy fell without done");
	c_paint: cover property (cmdValid && cmdReady && cmdOpcode[7:6] == 2'h2);
	c_copy: cover property (cmdValid && cmdReady && cmdOpcode[7:6] == 2'h3);
	c_queued: cover property (cmdValid && !cmdReady);
endmodule : draw_flag_asserts

// ==== dv/draw_flag_paint_pattern_control_tb.sv ====
`timescale 1ns/1ps
module draw_flag_paint_pattern_control_tb;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic opDone = 1'b0;
	logic memRdReq;
	logic [23:0] memRdAddr;
	logic memRdValid = 1'b0;
	logic [15:0] memRdData = 16'h0000;
	logic patValid;
	logic [15:0] patWord;
	logic [4:0] patPlane;
	logic [15:0] patRow;
	logic [15:0] probeColor = 16'h0000;
	logic probeStart = 1'b0;
	logic probeValid = 1'b0;
	logic isBoundary, cw, bsm, leftInc, rightInc, swp, mir, ht, gap, hwd, qm;
	logic [1:0] pts;
	logic [1:0] cv;
	logic [31:0] rdata;
	logic rerr;
	logic [36:0] pq[$];
	int mc = 0;
	int bad_count = 0;
	int tests_run = 0;
	always #2 clk_sys = ~clk_sys;
	cmd_link_if cmd_link_if_i ();
	cmd_issuer cmd_issuer_i (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(cmd_link_if_i));
	draw_flag_engine draw_flag_engine_i (.clk_sys(clk_sys), .arst_n(arst_n), .link(cmd_link_if_i),
		.opDone(opDone), .memRdReq(memRdReq), .memRdAddr(memRdAddr), .memRdValid(memRdValid),
		.memRdData(memRdData), .patValid(patValid), .patWord(patWord), .patPlane(patPlane),
		.patRow(patRow), .probeColor(probeColor), .probeStart(probeStart),
		.probeValid(probeValid), .isBoundary(isBoundary), .clockwiseSelect(cw),
		.boundarySearchMode(bsm), .leftEdgeInclude(leftInc), .rightEdgeInclude(rightInc),
		.swapReadOrder(swp), .mirrorFlag(mir), .halfTurnFlag(ht), .planeTransferSelect(pts),
		.gapFillFlag(gap), .hostWriteDir(hwd), .quickMode(qm), .copyVariant(cv));
	draw_flag_asserts draw_flag_asserts_i (.clk_sys(clk_sys), .arst_n(arst_n),
		.cmdValid(cmd_link_if_i.cmdValid), .cmdReady(cmd_link_if_i.cmdReady),
		.cmdOpcode(cmd_link_if_i.cmdOpcode), .cmdFlags(cmd_link_if_i.cmdFlags),
		.busy(cmd_link_if_i.busy), .done(cmd_link_if_i.done));
	////////////////////////////////////////////////////////////////////////////////
	// Memory word depends on address so a wrong fetch address shows up
	function automatic logic [15:0] mw(input logic [23:0] a);
		return a[15:0] ^ 16'hA5A5;
	endfunction : mw
	always @(posedge clk_sys) begin
		memRdValid <= (memRdReq === 1'b1);
		memRdData <= (memRdReq === 1'b1) ? mw(memRdAddr) : ~memRdData;
		if (memRdReq === 1'b1) mc++;
		if (patValid === 1'b1) pq.push_back({patRow, patPlane, patWord});
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_sig(input bit forDone);
		int n;
		n = 0;
		#1;
		while ((forDone ? cmd_link_if_i.done : cmd_link_if_i.busy) !== 1'b1 && n < 300) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk(forDone ? "done" : "busy", 1, n < 300);
	endtask : wait_sig
	task automatic paint(input logic [31:0] cmd);
		pq.delete();
		mc = 0;
		apb(1, 8'h00, cmd);
		wait_sig(1);
	endtask : paint
	// Every scenario emits two words per row, so the row is the index halved
	task automatic pat(input int i, input logic [4:0] p, input logic [15:0] w);
		logic [36:0] s;
		s = (i < pq.size()) ? pq[i] : '1;
		chk("pattern", {11'h0, p, w}, {11'h0, s[20:0]});
		chk("patRow", i / 2, s[36:21]);
	endtask : pat
	task automatic probe(input logic s, input logic [15:0] c, input logic e);
		@(posedge clk_sys);
		probeColor <= c;
		probeStart <= s;
		probeValid <= ~s;
		@(posedge clk_sys);
		probeStart <= 1'b0;
		probeValid <= 1'b0;
		#1;
		if (!s) chk("isBoundary", e, isBoundary);
	endtask : probe
	task automatic finish_op;
		@(posedge clk_sys);
		opDone <= 1'b1;
		@(posedge clk_sys);
		opDone <= 1'b0;
		wait_sig(1);
	endtask : finish_op
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk("cmdReady", 1, cmd_link_if_i.cmdReady);
		apb(0, 8'h10, 32'h0000_0000);
		chk("PLANES", 32'h0010_FFFF, rdata);
		apb(0, 8'h1C, 32'h0000_0000);
		chk("STATUS", 32'h0000_0000, rdata);
		apb(1, 8'h40, 32'h0000_0001);
		chk("pslverr", 1, rerr);
	endtask : t_reset
	task automatic t_internal;
		apb(1, 8'h04, 32'h0000_5555);
		apb(1, 8'h10, 32'h0002_0003);
		apb(1, 8'h14, 32'h0000_0001);
		paint(32'h0000_8015);
		pat(0, 5'h00, 16'h5555);
		pat(1, 5'h01, 16'h5555);
		chk("reads", 0, mc);
		chk("edges", 32'h0000_0005, {cw, rightInc, leftInc});
		paint(32'h0000_8024);
		chk("edges", 32'h0000_0002, {cw, rightInc, leftInc});
		apb(0, 8'h04, 32'h0000_0000);
		chk("PATCNT", 32'h0000_5555, rdata);
	endtask : t_internal
	task automatic t_tiles;
		apb(1, 8'h04, 32'h0000_0002);
		apb(1, 8'h08, 32'h0000_0100);
		apb(1, 8'h14, 32'h0000_0003);
		paint(32'h0000_8006);
		for (int r = 0; r < 3; r++) begin
			pat(2 * r, 5'h00, mw(24'h00_0100 + r % 2));
			pat(2 * r + 1, 5'h01, mw(24'h00_0100 + r % 2));
		end
		chk("reads", 3, mc);
		apb(1, 8'h04, 32'h0000_0003);
		apb(1, 8'h08, 32'h0000_0200);
		apb(1, 8'h0C, 32'h0000_0010);
		apb(1, 8'h10, 32'h0003_0005);
		apb(1, 8'h14, 32'h0000_0002);
		paint(32'h0000_8002);
		for (int r = 0; r < 2; r++) begin
			pat(2 * r, 5'h00, mw(24'h00_0200 + r));
			pat(2 * r + 1, 5'h02, mw(24'h00_0220 + r));
		end
		chk("reads", 4, mc);
		paint(32'h0001_8002);
		for (int i = 0; i < 4; i++) pat(i, (i % 2) ? 5'h02 : 5'h00, 16'h0000);
		chk("reads", 0, mc);
	endtask : t_tiles
	task automatic t_boundary;
		apb(1, 8'h18, 32'h0000_1234);
		// Probes only count while a paint runs, so it gets enough rows to outlast them
		apb(1, 8'h14, 32'h0000_0010);
		apb(1, 8'h00, 32'h0000_8004);
		wait_sig(0);
		chk("mode", 0, bsm);
		probe(0, 16'h1234, 1);
		probe(0, 16'h1111, 0);
		wait_sig(1);
		apb(1, 8'h00, 32'h0000_800C);
		wait_sig(0);
		chk("mode", 1, bsm);
		probe(1, 16'h0007, 0);
		probe(0, 16'h0007, 0);
		probe(0, 16'h0008, 1);
		wait_sig(1);
	endtask : t_boundary
	task automatic t_flags;
		logic [16:0] tbl[13];
		tbl = '{17'h0C001, 17'h0C002, 17'h0C004, 17'h0C008, 17'h0C010, 17'h0C018, 17'h0C020,
			17'h0C040, 17'h1C080, 17'h0C180, 17'h0C088, 17'h18084, 17'h08086};
		foreach (tbl[i]) begin
			apb(1, 8'h00, {16'h0000, tbl[i][15:0]});
			wait_sig(0);
			chk("quickMode", tbl[i][16], qm);
			if (tbl[i][15:14] == 2'h3) begin
				chk("copyFlags", tbl[i][6:0], {hwd, gap, pts, ht, mir, swp});
				chk("copyVariant", tbl[i][9:8], cv);
				apb(0, 8'h1C, 32'h0000_0000);
				chk("STATUS", {tbl[i][7] & ~tbl[i][16], 1'b0, 1'b1}, rdata[2:0]);
				finish_op();
			end
			else wait_sig(1);
		end
		apb(1, 8'h00, 32'h0000_C002);
		wait_sig(0);
		apb(1, 8'h00, 32'h0000_C001);
		apb(0, 8'h1C, 32'h0000_0000);
		chk("pending", 3'h3, rdata[2:0]);
		chk("held", 2'h2, {mir, swp});
		finish_op();
		// The done cycle still shows busy; let the queued command start first
		repeat (2) @(posedge clk_sys);
		wait_sig(0);
		chk("next", 2'h1, {mir, swp});
		finish_op();
	endtask : t_flags
	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (10) @(posedge clk_sys);
		arst_n <= 1'b1;
		t_reset();
		t_internal();
		t_tiles();
		t_boundary();
		t_flags();
		tally_and_finish();
	end
	// Whole run needs several hundred cycles; far beyond that means a hang
	initial begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		tally_and_finish();
	end
endmodule : draw_flag_paint_pattern_control_tb

// ==== hdl/cmd_issuer.sv ====
`timescale 1ns/1ps
module cmd_issuer (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	cmd_link_if.host link
);
	logic pending;
	logic [7:0] opcode;
	logic [7:0] flags;
	logic [15:0] patCnt;
	logic [23:0] patBase;
	logic [23:0] stride;
	logic [15:0] mask;
	logic [4:0] limit;
	logic [15:0] rows;
	logic [15:0] color;
	logic quickStripped;
	logic [7:0] doneCnt;
	logic [31:0] readMux;

	////////////////////////////////////////////////////////////////////////
	// Decode
	wire access = psel && penable;
	wire setup = psel && !penable;
	wire hitCmd = (paddr == flag_pkg::OFS_CMD);
	wire hitCnt = (paddr == flag_pkg::OFS_PATCNT);
	wire hitBase = (paddr == flag_pkg::OFS_PATBASE);
	wire hitStride = (paddr == flag_pkg::OFS_STRIDE);
	wire hitPlanes = (paddr == flag_pkg::OFS_PLANES);
	wire hitRows = (paddr == flag_pkg::OFS_ROWS);
	wire hitColor = (paddr == flag_pkg::OFS_COLOR);
	wire hitStatus = (paddr == flag_pkg::OFS_STATUS);
	wire mapped = hitCmd || hitCnt || hitBase || hitStride || hitPlanes || hitRows ||
		hitColor || hitStatus;
	// A new command while one waits would overwrite it, so it is refused
	wire refuse = !mapped || (hitCmd && pwrite && pending);
	wire wr = access && pwrite && !refuse;
	wire clearReq = pwdata[flag_pkg::CMD_CLEAR_BIT];
	wire [1:0] newCls = pwdata[8 + flag_pkg::OP_CLASS_LO +: 2];
	wire newTile = pwdata[flag_pkg::F_TILE] && !clearReq;
	wire badFill = (newCls == flag_pkg::CLASS_PAINT) && newTile; // R19
	wire badCopy = (newCls == flag_pkg::CLASS_COPY) && ((pwdata[9:8] != 2'h0) ||
		(pwdata[flag_pkg::F_SEL_LO +: 2] != flag_pkg::SEL_SINGLE)); // R20
	wire stripFast = badFill || badCopy;

	assign pready = 1'b1;
	assign pslverr = access && refuse;

	always_comb begin
		readMux = 32'h0000_0000;
		if (hitCmd) readMux = {16'h0000, opcode, flags};
		if (hitCnt) readMux = {16'h0000, patCnt};
		if (hitBase) readMux = {8'h00, patBase};
		if (hitStride) readMux = {8'h00, stride};
		if (hitPlanes) readMux = {11'h000, limit, mask};
		if (hitRows) readMux = {16'h0000, rows};
		if (hitColor) readMux = {16'h0000, color};
		if (hitStatus) readMux = {16'h0000, doneCnt, 5'h00, quickStripped, pending, link.busy};
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			prdata <= readMux;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Parameter registers
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			patCnt <= 16'h0000;
			patBase <= 24'h0000_00;
			stride <= 24'h0000_00;
			mask <= flag_pkg::PLANE_MASK_RST;
			limit <= flag_pkg::PLANE_LIMIT_RST;
			rows <= 16'h0000;
			color <= 16'h0000;
		end else if (wr) begin
			if (hitCnt) patCnt <= pwdata[15:0]; // R8
			if (hitCmd && clearReq) patCnt <= 16'h0000; // R21
			if (hitBase) patBase <= pwdata[23:0]; // R8
			if (hitStride) stride <= pwdata[23:0];
			if (hitPlanes) mask <= pwdata[15:0];
			if (hitPlanes) limit <= pwdata[20:16];
			if (hitRows) rows <= pwdata[15:0];
			if (hitColor) color <= pwdata[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Command issue
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pending <= 1'b0;
			opcode <= 8'h00;
			flags <= 8'h00;
			quickStripped <= 1'b0;
		end else if (wr && hitCmd) begin
			pending <= 1'b1; // R1
			opcode <= pwdata[15:8];
			flags <= pwdata[7:0];
			flags[flag_pkg::F_TILE] <= newTile; // R21
			if (clearReq) flags[flag_pkg::F_SS] <= 1'b1; // R21
			flags[flag_pkg::F_FAST] <= pwdata[flag_pkg::F_FAST] && !stripFast; // R19 R20
			quickStripped <= pwdata[flag_pkg::F_FAST] && stripFast;
		end else if (link.cmdReady) begin
			pending <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			doneCnt <= 8'h00;
		end else if (link.done) begin
			doneCnt <= doneCnt + 8'h01;
		end
	end

	assign link.cmdValid = pending;
	assign link.cmdOpcode = opcode;
	assign link.cmdFlags = flags;
	assign link.patternCount = patCnt;
	assign link.patternBase = patBase;
	assign link.planeStride = stride;
	assign link.planeMask = mask;
	assign link.planeLimit = limit;
	assign link.rowCount = rows;
	assign link.boundaryColor = color;
endmodule : cmd_issuer

// ==== hdl/cmd_link_if.sv ====
`timescale 1ns/1ps
interface cmd_link_if;
	logic cmdValid;
	logic cmdReady;
	logic [7:0] cmdOpcode;
	logic [7:0] cmdFlags;
	logic [15:0] patternCount;
	logic [23:0] patternBase;
	logic [23:0] planeStride;
	logic [15:0] planeMask;
	logic [4:0] planeLimit;
	logic [15:0] rowCount;
	logic [15:0] boundaryColor;
	logic busy;
	logic done;
	modport device (input cmdValid, cmdOpcode, cmdFlags, patternCount, patternBase,
		planeStride, planeMask, planeLimit, rowCount, boundaryColor,
		output cmdReady, busy, done);
	modport host (output cmdValid, cmdOpcode, cmdFlags, patternCount, patternBase,
		planeStride, planeMask, planeLimit, rowCount, boundaryColor,
		input cmdReady, busy, done);
endinterface : cmd_link_if

// ==== hdl/draw_flag_engine.sv ====
`timescale 1ns/1ps
module draw_flag_engine (
	input wire logic clk_sys,
	input wire logic arst_n,
	cmd_link_if.device link,
	input wire logic opDone,
	output logic memRdReq,
	output logic [23:0] memRdAddr,
	input wire logic memRdValid,
	input wire logic [15:0] memRdData,
	output logic patValid,
	output logic [15:0] patWord,
	output logic [4:0] patPlane,
	output logic [15:0] patRow,
	input wire logic [15:0] probeColor,
	input wire logic probeStart,
	input wire logic probeValid,
	output logic isBoundary,
	output logic clockwiseSelect,
	output logic boundarySearchMode,
	output logic leftEdgeInclude,
	output logic rightEdgeInclude,
	output logic swapReadOrder,
	output logic mirrorFlag,
	output logic halfTurnFlag,
	output logic [1:0] planeTransferSelect,
	output logic gapFillFlag,
	output logic hostWriteDir,
	output logic quickMode,
	output logic [1:0] copyVariant
);
	flag_pkg::eng_state_t state;
	flag_pkg::eng_state_t next_state;
	logic [7:0] flags;
	logic [7:0] opcode;
	logic [15:0] patCnt;
	logic [23:0] patBase;
	logic [23:0] stride;
	logic [15:0] mask;
	logic [4:0] limit;
	logic [15:0] rows;
	logic [15:0] color;
	logic [4:0] planeIdx;
	logic [23:0] planeOff;
	logic [15:0] rowIdx;
	logic [15:0] phase;
	logic [15:0] curWord;
	logic [15:0] startColor;
	logic haveWord;

	////////////////////////////////////////////////////////////////////////
	// Decode
	wire start = (state == flag_pkg::ST_IDLE) && link.cmdValid;
	wire [1:0] startCls = link.cmdOpcode[flag_pkg::OP_CLASS_HI:flag_pkg::OP_CLASS_LO];
	wire [1:0] cls = opcode[flag_pkg::OP_CLASS_HI:flag_pkg::OP_CLASS_LO];
	wire isPaint = (cls == flag_pkg::CLASS_PAINT);
	wire isCopy = (cls == flag_pkg::CLASS_COPY);
	wire tile = flags[flag_pkg::F_TILE];
	wire single = flags[flag_pkg::F_SS];
	wire inPlane = (state == flag_pkg::ST_PLANE);
	wire planeEnd = (planeIdx >= limit) || (planeIdx[4] == 1'b1);
	wire planeOn = !planeEnd && mask[planeIdx[3:0]];
	// Shared tile word is fetched once per row and reused
	wire needFetch = tile && !(single && haveWord); // R4 R5 R6
	wire lastRow = (rowIdx + 16'h0001) >= rows;
	wire rowStep = inPlane && planeEnd;
	wire planeStep = (inPlane && !planeEnd && !planeOn) || (state == flag_pkg::ST_EMIT);
	wire fetchGo = inPlane && planeOn && needFetch;
	wire [23:0] fetchAddr = patBase + (single ? 24'h0000_00 : planeOff) + {8'h00, phase}; // R7

	assign link.cmdReady = (state == flag_pkg::ST_IDLE); // R1
	assign link.busy = (state != flag_pkg::ST_IDLE);
	assign link.done = (state == flag_pkg::ST_FINISH);

	////////////////////////////////////////////////////////////////////////
	// Held flag outputs
	assign clockwiseSelect = !isCopy && flags[flag_pkg::F_CW]; // R2
	assign boundarySearchMode = isPaint && flags[flag_pkg::F_SEARCH];
	assign leftEdgeInclude = !isCopy && flags[flag_pkg::F_LEFT]; // R11
	assign rightEdgeInclude = !isCopy && flags[flag_pkg::F_RIGHT]; // R11
	assign swapReadOrder = isCopy && flags[flag_pkg::F_SWAP]; // R12
	assign mirrorFlag = isCopy && flags[flag_pkg::F_MIRROR]; // R13
	assign halfTurnFlag = isCopy && flags[flag_pkg::F_HALF]; // R14
	assign planeTransferSelect = isCopy ? flags[flag_pkg::F_SEL_LO +: 2] : 2'h0; // R15
	assign gapFillFlag = isCopy && flags[flag_pkg::F_GAP]; // R16
	assign hostWriteDir = isCopy && flags[flag_pkg::F_PUT]; // R17
	assign quickMode = link.busy && flags[flag_pkg::F_FAST]; // R18
	assign copyVariant = isCopy ? opcode[1:0] : 2'h0;

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb begin
		next_state = state;
		case (state)
			flag_pkg::ST_IDLE: begin
				if (link.cmdValid) begin
					next_state = (startCls == flag_pkg::CLASS_PAINT) ?
						flag_pkg::ST_PLANE : flag_pkg::ST_HOLD;
				end
			end
			flag_pkg::ST_HOLD: begin
				if (opDone) begin
					next_state = flag_pkg::ST_FINISH;
				end
			end
			flag_pkg::ST_PLANE: begin
				if (planeEnd) begin
					next_state = lastRow ? flag_pkg::ST_FINISH : flag_pkg::ST_PLANE;
				end else if (planeOn) begin
					next_state = needFetch ? flag_pkg::ST_FETCH : flag_pkg::ST_EMIT;
				end
			end
			flag_pkg::ST_FETCH: begin
				if (memRdValid) begin
					next_state = flag_pkg::ST_EMIT;
				end
			end
			flag_pkg::ST_EMIT: next_state = flag_pkg::ST_PLANE;
			flag_pkg::ST_FINISH: next_state = flag_pkg::ST_IDLE;
			default: next_state = flag_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state <= flag_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Later link changes cannot disturb a running command
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			flags <= 8'h00;
			opcode <= 8'h00;
			patCnt <= 16'h0000;
			patBase <= 24'h0000_00;
			stride <= 24'h0000_00;
			mask <= 16'h0000;
			limit <= 5'h00;
			rows <= 16'h0000;
			color <= 16'h0000;
		end else if (start) begin
			flags <= link.cmdFlags; // R22
			opcode <= link.cmdOpcode; // R22
			patCnt <= link.patternCount;
			patBase <= link.patternBase;
			stride <= link.planeStride;
			mask <= link.planeMask;
			limit <= link.planeLimit;
			rows <= link.rowCount;
			color <= link.boundaryColor;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Plane and row walk
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			planeIdx <= 5'h00;
			planeOff <= 24'h0000_00;
			rowIdx <= 16'h0000;
		end else if (start || rowStep) begin
			planeIdx <= 5'h00;
			planeOff <= 24'h0000_00;
			rowIdx <= start ? 16'h0000 : rowIdx + 16'h0001;
		end else if (planeStep) begin
			planeIdx <= planeIdx + 5'h01;
			planeOff <= planeOff + stride; // R7
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			haveWord <= 1'b0;
		end else if (start || rowStep) begin
			haveWord <= 1'b0;
		end else if ((state == flag_pkg::ST_FETCH) && memRdValid) begin
			haveWord <= 1'b1; // R5
		end
	end

	// Pattern index wraps at the repeat count, one step per row
	pattern_phase_counter #(
		.W(16)
	) pattern_phase_counter_i (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.clear(start),
		.step(rowStep), // R4
		.limit(patCnt),
		.count(phase)
	);

	////////////////////////////////////////////////////////////////////////
	// Pattern word source
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			memRdReq <= 1'b0;
			memRdAddr <= 24'h0000_00;
		end else begin
			memRdReq <= fetchGo; // R4 R6
			if (fetchGo) begin
				memRdAddr <= fetchAddr;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			curWord <= 16'h0000;
		end else if (inPlane && planeOn && !tile) begin
			curWord <= patCnt; // R3
		end else if ((state == flag_pkg::ST_FETCH) && memRdValid) begin
			curWord <= memRdData; // R4
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			patValid <= 1'b0;
			patWord <= 16'h0000;
			patPlane <= 5'h00;
			patRow <= 16'h0000;
		end else begin
			patValid <= (state == flag_pkg::ST_EMIT);
			if (state == flag_pkg::ST_EMIT) begin
				patWord <= curWord; // R3 R5
				patPlane <= planeIdx;
				patRow <= rowIdx;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Boundary test for enclosed-area paint
	wire probeHit = boundarySearchMode ? (probeColor != startColor) : // R10
		(probeColor == color); // R9

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			startColor <= 16'h0000;
			isBoundary <= 1'b0;
		end else begin
			if (probeStart) begin
				startColor <= probeColor; // R10
			end
			isBoundary <= isPaint && link.busy && probeValid && probeHit;
		end
	end
endmodule : draw_flag_engine

// ==== hdl/flag_pkg.sv ====
// Function
// R1: Opcode byte write starts command; flags low
// R2: Clockwise flag picks curve tracing direction
// R3: Internal pattern register paints all planes
// R4: Tiling fetches memory words, advancing with Y
// R5: Shared tile word for planes on same row
// R6: Per-plane tiling reads separate pattern each plane
// R7: Plane pattern address steps by source stride
// R8: Host loads pattern base and repeat count
// R9: Mode 0 searches preset boundary color
// R10: Mode 1 treats non-start colors as boundary
// R11: Left/right edge bits include boundary points
// R12: Swap bit selects copy read order
// R13: Mirror bit reverses copied image
// R14: Half-turn bit rotates copied image
// R15: Plane transfer field selects plane data mode
// R16: Gap fill draws skipped rotated points
// R17: Host direction bit picks put or get
// R18: Quick bit selects accelerated drawing
// R19: Quick fill only replacing, untiled, unclipped
// R20: Quick copy only plain single-source replace
// R21: Clear planes with internal pattern setting
// R22: Flags latched at start, held until done
package flag_pkg;
	localparam int OP_CLASS_HI = 7;
	localparam int OP_CLASS_LO = 6;
	localparam logic [1:0] CLASS_PAINT = 2'h2;
	localparam logic [1:0] CLASS_COPY = 2'h3;
	localparam logic [1:0] SEL_SINGLE = 2'h0;
	// Paint and figure commands
	localparam int F_CW = 0;
	localparam int F_TILE = 1;
	localparam int F_SS = 2;
	localparam int F_SEARCH = 3;
	localparam int F_LEFT = 4;
	localparam int F_RIGHT = 5;
	localparam int F_FAST = 7;
	// Copy and put/get commands
	localparam int F_SWAP = 0;
	localparam int F_MIRROR = 1;
	localparam int F_HALF = 2;
	localparam int F_SEL_LO = 3;
	localparam int F_GAP = 5;
	localparam int F_PUT = 6;
	localparam int CMD_CLEAR_BIT = 16;
	// Register offsets of the command front end
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_PATCNT = 8'h04;
	localparam logic [7:0] OFS_PATBASE = 8'h08;
	localparam logic [7:0] OFS_STRIDE = 8'h0C;
	localparam logic [7:0] OFS_PLANES = 8'h10;
	localparam logic [7:0] OFS_ROWS = 8'h14;
	localparam logic [7:0] OFS_COLOR = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1C;
	localparam logic [4:0] PLANE_LIMIT_RST = 5'h10;
	localparam logic [15:0] PLANE_MASK_RST = 16'hFFFF;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_HOLD = 3'b001,
		ST_PLANE = 3'b010,
		ST_FETCH = 3'b011,
		ST_EMIT = 3'b100,
		ST_FINISH = 3'b101
	} eng_state_t;
endpackage : flag_pkg

// ==== hdl/pattern_phase_counter.sv ====
`timescale 1ns/1ps
module pattern_phase_counter #(
	parameter int W = 16
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic clear,
	input wire logic step,
	input wire logic [W-1:0] limit,
	output logic [W-1:0] count
);
	logic [W-1:0] countInc;
	logic wrap;
	assign countInc = count + 1'b1;
	// A zero limit behaves as one word, so the phase stays at 0
	assign wrap = (countInc >= limit);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			count <= '0;
		end else if (clear) begin
			count <= '0;
		end else if (step) begin
			count <= wrap ? '0 : countInc;
		end
	end
endmodule : pattern_phase_counter
